// >>> include/bb_regs_defs.svh
// offsets, field positions, reset values and timing counts of the buck-boost control block
// assumes a 25 MHz core clock and byte-wide register access from the serial host port engine
`ifndef BB_REGS_DEFS_SVH
`define BB_REGS_DEFS_SVH

`define BB_ADDR_BUCK3_READBACK 8'h3f
`define BB_ADDR_ENABLE 8'h40
`define BB_ADDR_CONFIG 8'h41

`define BB_ENABLE_RESET 8'h00
`define BB_CONFIG_RESET 8'h00
`define BB_ENABLE_WMASK 8'h03
`define BB_CONFIG_WMASK 8'h9f
`define BB_READBACK_MASK 8'h3f

`define BB_SEQ_MSB 7
`define BB_SEQ_LSB 5
`define BB_SWEN_MSB 1
`define BB_SWEN_LSB 0

`define BB_SEQ_DISABLED 3'h0
`define BB_SEQ_AT_0 3'h2
`define BB_SEQ_AT_25 3'h3
`define BB_SEQ_AT_50 3'h4
`define BB_SEQ_SOFTWARE 3'h7

`define BB_SWEN_OFF 2'h0
`define BB_SWEN_ON 2'h1
`define BB_SWEN_PIN 2'h2

`define BB_CLK_PERIOD_NS 40
`define BB_RAMP_STEP_NS 20000
`define BB_RAMP_STEP_CYCLES ((`BB_RAMP_STEP_NS) / (`BB_CLK_PERIOD_NS))

`endif

// >>> include/bb_regs_pkg.sv
// types shared by the buck-boost control block
// assumes the host port engine presents one byte access per strobe
package bb_regs_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic table_bypass;
        logic [1:0] unused;
        logic slow_edges;
        logic active_sel;
        logic ramp_en;
        logic topology;
        logic passive_sel;
    } bb_cfg_t;

endpackage

// >>> src/bb_ramp_stepper.sv
// applied voltage code follower with optional upward ramp
// assumes the target code is synchronous to clk
`include "bb_regs_defs.svh"

module bb_ramp_stepper #(
    parameter int STEP_CYCLES = `BB_RAMP_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ramp_en,
    input wire logic [5:0] target,
    output logic [5:0] applied
);

    generate
        if (STEP_CYCLES < 2 || STEP_CYCLES > 65535) begin : g_bad
            $error("bb_ramp_stepper: STEP_CYCLES out of range");
        end
    endgenerate

    localparam logic [15:0] LAST = 16'(STEP_CYCLES - 1);

    logic [15:0] count;
    logic [15:0] next_count;
    logic [5:0] next_applied;

    always_comb begin
        next_count = count;
        next_applied = applied;
        if (ramp_en && target > applied) begin
            // one code per step interval, counted from the first pending rise
            if (count == LAST) begin
                next_count = 16'h0000;
                next_applied = applied + 6'h01; // R10
            end else begin
                next_count = count + 16'h0001;
            end
        end else begin
            next_count = 16'h0000;
            next_applied = target; // R10
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= 16'h0000;
            applied <= 6'h00;
        end else begin
            count <= next_count;
            applied <= next_applied;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ramp_one_step_a: assert property ( // R10
        ($past(ramp_en) && $past(target) > $past(applied) && applied != $past(applied))
        |-> applied == $past(applied) + 6'h01
    ) else $error("ramp moved by more than one code");

    ramp_jump_a: assert property ( // R10
        !ramp_en |=> applied == $past(target)
    ) else $error("ramp disabled but setting did not jump");

endmodule // bb_ramp_stepper

// >>> src/buckboost_enable_config_regs.sv
// buck-boost enable and configuration registers with buck three voltage readback
// assumes a host port engine issuing byte reads and writes synchronous to clk,
// and a boot sequencer giving level milestones that stay high once reached
`include "bb_regs_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// R1: buck three voltage code readable, six bits
// R2: boot sequence code read only, bits 7:5
// R3: codes 010/011/100 enable at 0/25/50 percent
// R4: code 111 hands enable to software after boot
// R5: software enable ignored unless sequence code 111
// R6: software code off, on, pin, reserved
// R7: table bypass bit selects programmed peak current
// R8: slow edges bit slows switch node edges
// R9: active discharge on hard reset, optionally enable low; code skips the enable-low case while software code is off under sequence code 111
// R10: ramp steps up every 20 us, else jumps
// R11: passive discharge on hard reset, optionally enable low
// R12: unassigned bits read zero, writes ignored
module buckboost_enable_config_regs #(
    parameter int RAMP_STEP_CYCLES = `BB_RAMP_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire bb_regs_pkg::reg_req_t reg_req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic [2:0] boot_seq_strap,
    input wire logic boot_started,
    input wire logic boot_quarter,
    input wire logic boot_half,
    input wire logic boot_complete,
    input wire logic multipurpose_control_pin,
    input wire logic hard_reset,
    input wire logic shutdown_mode,
    input wire logic [5:0] buck_three_voltage_readback,
    input wire logic [5:0] target_vset,
    output logic bb_enable,
    output logic bb_active_discharge,
    output logic bb_passive_discharge,
    output logic bb_slow_edges,
    output logic bb_current_table_bypass,
    output logic bb_topology_select,
    output logic [5:0] bb_applied_vset
);

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [2:0] bb_boot_sequence_code;
    logic seq_loaded;
    logic [1:0] bb_software_enable;
    bb_regs_pkg::bb_cfg_t bb_config_reg;
    logic [2:0] next_seq;
    logic next_seq_loaded;
    logic [1:0] next_swen;
    bb_regs_pkg::bb_cfg_t next_cfg;
    logic [7:0] next_rdata;
    logic next_rvalid;

    always_comb begin
        next_seq = bb_boot_sequence_code;
        next_seq_loaded = 1'b1;
        next_swen = bb_software_enable;
        next_cfg = bb_config_reg;
        next_rdata = rdata;
        next_rvalid = reg_req.rd;
        // strap is caught once after reset release; software cannot write it
        if (!seq_loaded) begin
            next_seq = boot_seq_strap; // R2
        end
        if (reg_req.wr && reg_req.addr == `BB_ADDR_ENABLE) begin
            next_swen = reg_req.wdata[`BB_SWEN_MSB:`BB_SWEN_LSB]; // R12
        end
        if (reg_req.wr && reg_req.addr == `BB_ADDR_CONFIG) begin
            next_cfg = bb_regs_pkg::bb_cfg_t'(reg_req.wdata & `BB_CONFIG_WMASK); // R12
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                `BB_ADDR_BUCK3_READBACK: next_rdata = {2'h0, buck_three_voltage_readback}; // R1
                `BB_ADDR_ENABLE: next_rdata = {bb_boot_sequence_code, 3'h0, bb_software_enable};
                `BB_ADDR_CONFIG: next_rdata = bb_config_reg & `BB_CONFIG_WMASK; // R12
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bb_boot_sequence_code <= `BB_SEQ_DISABLED;
            seq_loaded <= 1'b0;
            bb_software_enable <= 2'(`BB_ENABLE_RESET);
            bb_config_reg <= `BB_CONFIG_RESET;
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            bb_boot_sequence_code <= next_seq;
            seq_loaded <= next_seq_loaded;
            bb_software_enable <= next_swen;
            bb_config_reg <= next_cfg;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable and discharge control

    logic sw_off;
    logic next_enable;
    logic next_active;
    logic next_passive;

    always_comb begin
        next_enable = 1'b0;
        sw_off = 1'b0;
        if (seq_loaded) begin
            case (bb_boot_sequence_code)
                `BB_SEQ_AT_0: next_enable = boot_started; // R3
                `BB_SEQ_AT_25: next_enable = boot_quarter; // R3
                `BB_SEQ_AT_50: next_enable = boot_half; // R3
                `BB_SEQ_SOFTWARE: begin
                    // software field matters only here; elsewhere it is inert
                    if (boot_complete) begin // R4 R5
                        case (bb_software_enable)
                            `BB_SWEN_ON: next_enable = 1'b1; // R6
                            `BB_SWEN_PIN: next_enable = multipurpose_control_pin; // R6
                            default: next_enable = 1'b0; // R6
                        endcase
                    end
                    sw_off = bb_software_enable == `BB_SWEN_OFF;
                end
                default: next_enable = 1'b0; // R2
            endcase
        end
        // hard reset forces both discharges, shutdown the active one; enable low adds them when selected, the active one unless code 111 has software off
        next_active = hard_reset || shutdown_mode
            || (bb_config_reg.active_sel && !next_enable && !sw_off); // R6 R9
        next_passive = hard_reset || (bb_config_reg.passive_sel && !next_enable); // R11
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bb_enable <= 1'b0;
            bb_active_discharge <= 1'b0;
            bb_passive_discharge <= 1'b0;
            bb_slow_edges <= 1'b0;
            bb_current_table_bypass <= 1'b0;
            bb_topology_select <= 1'b0;
        end else begin
            bb_enable <= next_enable;
            bb_active_discharge <= next_active;
            bb_passive_discharge <= next_passive;
            bb_slow_edges <= bb_config_reg.slow_edges; // R8
            bb_current_table_bypass <= bb_config_reg.table_bypass; // R7
            bb_topology_select <= bb_config_reg.topology;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // voltage ramp

    bb_ramp_stepper #(
        .STEP_CYCLES(RAMP_STEP_CYCLES)
    ) u_ramp (
        .clk(clk),
        .rst_n(rst_n),
        .ramp_en(bb_config_reg.ramp_en),
        .target(target_vset),
        .applied(bb_applied_vset)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    seq_read_only_a: assert property ( // R2
        seq_loaded |=> bb_boot_sequence_code == $past(bb_boot_sequence_code)
    ) else $error("boot sequence code changed after load");

    seq_disabled_a: assert property ( // R2
        (seq_loaded && bb_boot_sequence_code == `BB_SEQ_DISABLED) |=> !bb_enable
    ) else $error("enabled with sequence code disabled");

    boot_quarter_a: assert property ( // R3
        (seq_loaded && bb_boot_sequence_code == `BB_SEQ_AT_25) |=> bb_enable == $past(boot_quarter)
    ) else $error("quarter sequence enable wrong");

    sw_handoff_a: assert property ( // R4
        (seq_loaded && bb_boot_sequence_code == `BB_SEQ_SOFTWARE && boot_complete
         && bb_software_enable == `BB_SWEN_ON) |=> bb_enable
    ) else $error("software enable not honoured after boot");

    sw_ignored_a: assert property ( // R5
        (seq_loaded && bb_boot_sequence_code != `BB_SEQ_SOFTWARE
         && !(bb_boot_sequence_code == `BB_SEQ_AT_0 && boot_started)
         && !(bb_boot_sequence_code == `BB_SEQ_AT_25 && boot_quarter)
         && !(bb_boot_sequence_code == `BB_SEQ_AT_50 && boot_half)) |=> !bb_enable
    ) else $error("software field leaked into boot sequence");

    pin_follow_a: assert property ( // R6
        (seq_loaded && bb_boot_sequence_code == `BB_SEQ_SOFTWARE && boot_complete
         && bb_software_enable == `BB_SWEN_PIN) |=> bb_enable == $past(multipurpose_control_pin)
    ) else $error("pin controlled enable wrong");

    bypass_follow_a: assert property ( // R7
        reg_req.wr && reg_req.addr == `BB_ADDR_CONFIG |=> ##1 bb_current_table_bypass == $past(reg_req.wdata[7], 2)
    ) else $error("table bypass not applied");

    slow_edges_a: assert property ( // R8
        reg_req.wr && reg_req.addr == `BB_ADDR_CONFIG |=> ##1 bb_slow_edges == $past(reg_req.wdata[4], 2)
    ) else $error("slow edges not applied");

    active_dsc_a: assert property ( // R9
        hard_reset |=> bb_active_discharge
    ) else $error("no active discharge in hard reset");

    active_sel_off_a: assert property ( // R9
        (!hard_reset && !shutdown_mode && !bb_config_reg.active_sel) |=> !bb_active_discharge
    ) else $error("active discharge without cause");

    passive_dsc_a: assert property ( // R11
        (!hard_reset && !bb_config_reg.passive_sel) |=> !bb_passive_discharge
    ) else $error("passive discharge without cause");

    reserved_zero_a: assert property ( // R12
        reg_req.rd && reg_req.addr == `BB_ADDR_ENABLE |=> rvalid && rdata[4:2] == 3'h0
    ) else $error("unassigned enable bits not zero");

    readback_a: assert property ( // R1
        reg_req.rd && reg_req.addr == `BB_ADDR_BUCK3_READBACK
        |=> rdata == {2'h0, $past(buck_three_voltage_readback)}
    ) else $error("buck three readback wrong");

endmodule // buckboost_enable_config_regs

// >>> testbench/test_buckboost_enable_config_regs.sv
// self-checking bench for the buck-boost enable and configuration registers
// assumes read data one cycle after the strobe and the sequence strap caught after reset
module test_buckboost_enable_config_regs;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    bb_regs_pkg::reg_req_t req = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic [2:0] strap = 3'h0;
    logic [3:0] mile = 4'h0;
    logic pin = 1'b0;
    logic hrst = 1'b0;
    logic shut = 1'b0;
    logic [5:0] rb = 6'h00;
    logic [5:0] tgt = 6'h00;
    logic en;
    logic act;
    logic psv;
    logic slow;
    logic byp;
    logic topo;
    logic [5:0] applied;
    int n_errors = 0;
    int checked = 0;

    ////////////////////////////////////////////////////////////////////////////
    // short ramp step keeps the run brief
    buckboost_enable_config_regs #(.RAMP_STEP_CYCLES(4)) dut_u (
        .clk(clk), .rst_n(rst_n), .reg_req(req), .rdata(rdata), .rvalid(rvalid),
        .boot_seq_strap(strap), .boot_started(mile[0]), .boot_quarter(mile[1]),
        .boot_half(mile[2]), .boot_complete(mile[3]), .multipurpose_control_pin(pin),
        .hard_reset(hrst), .shutdown_mode(shut), .buck_three_voltage_readback(rb),
        .target_vset(tgt), .bb_enable(en), .bb_active_discharge(act),
        .bb_passive_discharge(psv), .bb_slow_edges(slow), .bb_current_table_bypass(byp),
        .bb_topology_select(topo), .bb_applied_vset(applied)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req = '0;
        chk("rvalid", 8'h01, {7'h00, rvalid});
        chk("rdata", exp, rdata);
    endtask

    // strap held steady so the capture after release is unambiguous
    task automatic reset(input logic [2:0] s);
        @(negedge clk);
        rst_n = 1'b0;
        strap = s;
        mile = 4'h0;
        cyc(5);
        rst_n = 1'b1;
        cyc(2);
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset(3'h0);
        rd(8'h40, 8'h00);
        rd(8'h41, 8'h00);
        chk("enable", 8'h00, {7'h00, en});
        $display("test reset done");

        wr(8'h40, 8'hff);
        rd(8'h40, 8'h03);
        wr(8'h41, 8'hff);
        rd(8'h41, 8'h9f);
        cyc(2);
        chk("table_bypass", 8'h01, {7'h00, byp});
        chk("slow_edges", 8'h01, {7'h00, slow});
        chk("active_dsc", 8'h01, {7'h00, act});
        chk("passive_dsc", 8'h01, {7'h00, psv});
        chk("topology", 8'h01, {7'h00, topo});
        wr(8'h41, 8'h00);
        cyc(2);
        chk("table_bypass", 8'h00, {7'h00, byp});
        chk("slow_edges", 8'h00, {7'h00, slow});
        chk("active_dsc", 8'h00, {7'h00, act});
        chk("passive_dsc", 8'h00, {7'h00, psv});
        chk("topology", 8'h00, {7'h00, topo});
        hrst = 1'b1;
        cyc(2);
        chk("active_dsc", 8'h01, {7'h00, act});
        chk("passive_dsc", 8'h01, {7'h00, psv});
        hrst = 1'b0;
        shut = 1'b1;
        cyc(2);
        chk("active_dsc", 8'h01, {7'h00, act});
        chk("passive_dsc", 8'h00, {7'h00, psv});
        shut = 1'b0;
        rb = 6'h2a;
        wr(8'h3f, 8'hff);
        rd(8'h3f, 8'h2a);
        rd(8'h50, 8'h00);
        $display("test config done");

        // every strap code except 111, software enable written but not in charge
        for (int c = 0; c < 7; c++) begin
            reset(c[2:0]);
            wr(8'h40, 8'h01);
            rd(8'h40, {c[2:0], 5'h01});
            // last step raises boot_complete too, which must stay inert here
            for (int m = 0; m < 5; m++) begin
                mile = 4'((1 << m) - 1);
                cyc(3);
                chk("enable", {7'h00, (c == 2 && m > 0) || (c == 3 && m > 1) || (c == 4 && m > 2)},
                    {7'h00, en});
            end
        end
        $display("test sequence done");

        reset(3'h7);
        wr(8'h40, 8'h01);
        mile = 4'h7;
        cyc(3);
        chk("enable", 8'h00, {7'h00, en});
        mile = 4'hf;
        cyc(3);
        chk("enable", 8'h01, {7'h00, en});
        pin = 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(8'h40, 8'(s));
            cyc(3);
            chk("enable", {7'h00, s == 1 || s == 2}, {7'h00, en});
        end
        wr(8'h40, 8'h02);
        pin = 1'b0;
        cyc(3);
        chk("enable", 8'h00, {7'h00, en});
        wr(8'h41, 8'h08);
        cyc(3);
        chk("active_dsc", 8'h01, {7'h00, act});
        wr(8'h40, 8'h00);
        cyc(3);
        chk("active_dsc", 8'h00, {7'h00, act});
        wr(8'h40, 8'h03);
        cyc(3);
        chk("enable", 8'h00, {7'h00, en});
        chk("active_dsc", 8'h01, {7'h00, act});
        wr(8'h40, 8'h01);
        cyc(3);
        chk("active_dsc", 8'h00, {7'h00, act});
        $display("test software enable done");

        tgt = 6'h0a;
        cyc(3);
        chk("applied", 8'h0a, {2'h0, applied});
        wr(8'h41, 8'h04);
        cyc(2);
        tgt = 6'h0d;
        cyc(2);
        chk("applied", 8'h0a, {2'h0, applied});
        cyc(3);
        chk("applied", 8'h0b, {2'h0, applied});
        cyc(4);
        chk("applied", 8'h0c, {2'h0, applied});
        cyc(9);
        chk("applied", 8'h0d, {2'h0, applied});
        tgt = 6'h05;
        cyc(2);
        chk("applied", 8'h05, {2'h0, applied});
        $display("test ramp done");
        stop_test();
    end
endmodule // test_buckboost_enable_config_regs
